// ===== core/ecg_event_router.sv
`timescale 1ns/10ps
module ecg_event_router (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ecg_pkg::NUM_CHANNELS*ecg_pkg::SEL_W-1:0] sel_flat,
  input wire logic [ecg_pkg::NUM_CHANNELS-1:0] software_event_trigger,
  input wire logic rtc_overflow_event,
  input wire logic rtc_compare_match_event,
  input wire logic [ecg_pkg::NUM_PIT_TAPS-1:0] periodic_tap,
  input wire logic [ecg_pkg::NUM_LUTS-1:0] lookup_table_output,
  input wire logic [ecg_pkg::NUM_CMPS-1:0] analog_comparator,
  input wire logic result_ready_event,
  input wire logic sample_ready_event,
  input wire logic window_match_event,
  input wire logic [ecg_pkg::NUM_PINS-1:0] pin_level_event,
  input wire logic baud_clock_event,
  input wire logic spi_clock_event,
  input wire logic timer_a_split_mode,
  input wire logic overflow_or_low_underflow_event,
  input wire logic high_byte_underflow_event,
  input wire logic compare_zero_event,
  input wire logic compare_one_event,
  input wire logic compare_two_event,
  input wire logic [ecg_pkg::NUM_TIMER_B-1:0] capture_flag_event,
  input wire logic [ecg_pkg::NUM_TIMER_B-1:0] overflow_event,
  output logic [ecg_pkg::NUM_CHANNELS-1:0] async_subchannel,
  output logic [ecg_pkg::NUM_CHANNELS-1:0] sync_subchannel
);
  import ecg_pkg::*;

  typedef struct packed {
    logic [NUM_CHANNELS*SEL_W-1:0] sel;
    logic [NUM_CHANNELS-1:0] sync1;
    logic [NUM_CHANNELS-1:0] sync2;
    logic [NUM_CHANNELS-1:0] sync_path;
    logic [NUM_CHANNELS-1:0] sw;
  } ecg_state_type;

  ecg_state_type state_r;
  ecg_state_type state_nxt;

  logic [NUM_CHANNELS-1:0] raw_event;
  logic [NUM_CHANNELS-1:0] is_async;

  // Selection decode; the pure mux keeps async sources unclocked.
  always_comb begin
    logic [SEL_W-1:0] s;
    s = '0;
    raw_event = '0;
    is_async = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      s = state_r.sel[c*SEL_W +: SEL_W];
      // Unknown codes, including the reset code, drive nothing.
      raw_event[c] = 1'b0;
      is_async[c] = 1'b0;
      case (s)
        SEL_RTC_OVF: begin
          raw_event[c] = rtc_overflow_event;
          is_async[c] = 1'b1;
        end
        SEL_RTC_CMP: begin
          raw_event[c] = rtc_compare_match_event;
          is_async[c] = 1'b1;
        end
        SEL_ADC_RES: raw_event[c] = result_ready_event;
        SEL_ADC_SAMPLE_READY_EVENT: raw_event[c] = sample_ready_event;
        SEL_ADC_WIN: raw_event[c] = window_match_event;
        SEL_BAUD: raw_event[c] = baud_clock_event;
        SEL_SPI_CLK: raw_event[c] = spi_clock_event;
        SEL_TA_OVF: raw_event[c] = overflow_or_low_underflow_event;
        SEL_TA_HIGH_BYTE_UNDERFLOW_EVENT: begin
          raw_event[c] = high_byte_underflow_event
            & timer_a_split_mode;
        end
        default: begin
          for (int i = 0; i < NUM_PIT_TAPS; i++) begin
            if (s == SEL_PIT_BASE + SEL_W'(i)) begin
              raw_event[c] = periodic_tap[i];
              is_async[c] = 1'b1;
            end
          end
          for (int i = 0; i < NUM_LUTS; i++) begin
            if (s == SEL_LUT_BASE + SEL_W'(i)) begin
              raw_event[c] = lookup_table_output[i];
              is_async[c] = 1'b1;
            end
          end
          for (int i = 0; i < NUM_CMPS; i++) begin
            if (s == SEL_CMP_BASE + SEL_W'(i)) begin
              raw_event[c] = analog_comparator[i];
              is_async[c] = 1'b1;
            end
          end
          for (int i = 0; i < NUM_PINS; i++) begin
            if (s == SEL_PIN_BASE + SEL_W'(i)) begin
              raw_event[c] = pin_level_event[i];
              is_async[c] = 1'b1;
            end
          end
          for (int i = 0; i < NUM_TA_CMP; i++) begin
            if (s == SEL_TA_CMP0 + SEL_W'(i)) begin
              raw_event[c] = (i == 0) ? compare_zero_event :
                (i == 1) ? compare_one_event :
                compare_two_event;
            end
          end
          for (int i = 0; i < NUM_TIMER_B; i++) begin
            if (s == SEL_TB_CAPTURE_FLAG_EVENT + SEL_W'(i * TB_STRIDE)) begin
              raw_event[c] = capture_flag_event[i];
            end
            if (s == SEL_TB_OVF + SEL_W'(i * TB_STRIDE)) begin
              raw_event[c] = overflow_event[i];
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.sel = sel_flat;
    // Two flops; the first is read only by the second.
    state_nxt.sync1 = raw_event;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.sw = software_event_trigger;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      state_nxt.sync_path[c] = is_async[c] ? state_r.sync2[c]
        : raw_event[c];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Async path is combinational so it works with the clock stopped.
  always_comb begin
    async_subchannel = raw_event ^ state_r.sw;
    sync_subchannel = state_r.sync_path ^ state_r.sw;
  end
endmodule : ecg_event_router

// ===== core/ecg_pkg.sv
package ecg_pkg;
  // Number of event channels.
  localparam int unsigned NUM_CHANNELS = 6;
  // Width of a generator selection code.
  localparam int unsigned SEL_W = 8;
  // Selection code after reset: channel not connected.
  localparam logic [7:0] SEL_OFF = 8'h00;
  // Generator selection codes.
  localparam logic [7:0] SEL_RTC_OVF = 8'h06;
  localparam logic [7:0] SEL_RTC_CMP = 8'h07;
  localparam logic [7:0] SEL_PIT_BASE = 8'h08;
  localparam int unsigned NUM_PIT_TAPS = 8;
  localparam logic [7:0] SEL_LUT_BASE = 8'h10;
  localparam int unsigned NUM_LUTS = 4;
  localparam logic [7:0] SEL_CMP_BASE = 8'h20;
  localparam int unsigned NUM_CMPS = 1;
  localparam logic [7:0] SEL_ADC_RES = 8'h24;
  localparam logic [7:0] SEL_ADC_SAMPLE_READY_EVENT = 8'h25;
  localparam logic [7:0] SEL_ADC_WIN = 8'h26;
  localparam logic [7:0] SEL_PIN_BASE = 8'h40;
  localparam int unsigned NUM_PINS = 8;
  localparam logic [7:0] SEL_BAUD = 8'h60;
  localparam logic [7:0] SEL_SPI_CLK = 8'h68;
  localparam logic [7:0] SEL_TA_OVF = 8'h80;
  localparam logic [7:0] SEL_TA_HIGH_BYTE_UNDERFLOW_EVENT = 8'h81;
  localparam logic [7:0] SEL_TA_CMP0 = 8'h84;
  localparam logic [7:0] SEL_TB_CAPTURE_FLAG_EVENT = 8'hA0;
  localparam logic [7:0] SEL_TB_OVF = 8'hA1;
  localparam int unsigned NUM_TIMER_B = 2;
  localparam int unsigned TB_STRIDE = 2;
  localparam int unsigned NUM_TA_CMP = 3;
  // Periodic taps: slowest divides by 8192, fastest by 64.
  localparam int unsigned PIT_SLOWEST_DIV = 8192;
  localparam int unsigned PIT_FASTEST_DIV = 64;
endpackage : ecg_pkg

// ===== verif/ecg_event_router_props.sv
`timescale 1ns/10ps
module ecg_event_router_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [47:0] sel_flat,
  input wire logic [5:0] software_event_trigger,
  input wire logic [7:0] pin_level_event,
  input wire logic [3:0] lookup_table_output,
  input wire logic result_ready_event,
  input wire logic baud_clock_event,
  input wire logic timer_a_split_mode,
  input wire logic [5:0] async_subchannel,
  input wire logic [5:0] sync_subchannel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_held(logic [7:0] code);
    sel_flat[7:0] == code && !software_event_trigger[0];
  endsequence
  reset_off_a: assert property ($rose(reset_n) |->
    async_subchannel == 6'h00 && sync_subchannel == 6'h00) else $error("r");
  pin_async_a: assert property (s_held(8'h40) |=>
    async_subchannel[0] == pin_level_event[0]) else $error("pin async");
  lut_async_a: assert property (s_held(8'h11) |=>
    async_subchannel[0] == lookup_table_output[1]) else $error("lut");
  adc_sync_a: assert property (s_held(8'h24) ##1 s_held(8'h24) |=>
    sync_subchannel[0] == $past(result_ready_event)) else $error("adc");
  baud_sync_a: assert property (s_held(8'h60) ##1 s_held(8'h60) |=>
    sync_subchannel[0] == $past(baud_clock_event)) else $error("baud");
  pin_sync_a: assert property (s_held(8'h40)[*4] |=>
    sync_subchannel[0] == $past(pin_level_event[0], 3)) else $error("sync");
  high_byte_underflow_event_gate_a: assert property (s_held(8'h81) ##0 !timer_a_split_mode |=>
    timer_a_split_mode || !async_subchannel[0]) else $error("high_byte_underflow_event");
  sw_invert_a: assert property (s_held(8'h00)[*3] ##1
    (sel_flat[7:0] == 8'h00 && software_event_trigger[0])
    |=> async_subchannel[0] && sync_subchannel[0]) else $error("sw");
endmodule : ecg_event_router_props
bind ecg_event_router ecg_event_router_props i_props (.clk, .reset_n,
  .sel_flat, .software_event_trigger, .pin_level_event, .lookup_table_output,
  .result_ready_event, .baud_clock_event, .timer_a_split_mode,
  .async_subchannel, .sync_subchannel);

// ===== verif/ecg_event_router_tb_top.sv
`timescale 1ns/10ps
module ecg_event_router_tb_top;
  logic clk = 0, reset_n = 0, split = 0;
  logic [47:0] sel = '0;
  logic [5:0] sw = '0, a_o, s_o, ea, es;
  logic [31:0] rnd = '0, seed = 32'h1D85, r;
  logic [36:0] v;
  logic [3:0][42:0] h = '0;
  int n_errors = 0, checked = 0;
  logic [7:0] tbl [25] = '{8'h00, 8'h06, 8'h07, 8'h08, 8'h0F, 8'h10, 8'h11,
    8'h13, 8'h20, 8'h24, 8'h25, 8'h26, 8'h40, 8'h47, 8'h60, 8'h68, 8'h80,
    8'h81, 8'h84, 8'h86, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'h30};
  ecg_src_model i_ecg_src_model (.clk, .reset_n, .rnd, .v);
  ecg_event_router i_ecg_event_router (.clk, .reset_n, .sel_flat(sel),
    .software_event_trigger(sw), .rtc_overflow_event(v[22]),
    .rtc_compare_match_event(v[21]), .periodic_tap(v[20:13]),
    .lookup_table_output(v[12:9]), .analog_comparator(v[8:8]),
    .result_ready_event(v[23]), .sample_ready_event(v[24]),
    .window_match_event(v[25]), .pin_level_event(v[7:0]),
    .baud_clock_event(v[26]), .spi_clock_event(v[27]),
    .timer_a_split_mode(split), .overflow_or_low_underflow_event(v[28]),
    .high_byte_underflow_event(v[29]), .compare_zero_event(v[30]),
    .compare_one_event(v[31]), .compare_two_event(v[32]),
    .capture_flag_event({v[35], v[33]}), .overflow_event({v[36], v[34]}),
    .async_subchannel(a_o), .sync_subchannel(s_o));
  function automatic logic f(logic [7:0] c, logic [36:0] x);
    if (c[7:3] == 5'h08) return x[c[2:0]];
    if (c[7:3] == 5'h01) return x[13 + c[2:0]];
    if (c[7:2] == 6'h04) return x[9 + c[1:0]];
    case (c)
      8'h06: return x[22];
      8'h07: return x[21];
      8'h20: return x[8];
      8'h24, 8'h25, 8'h26: return x[23 + c[1:0]];
      8'h60: return x[26];
      8'h68: return x[27];
      8'h80: return x[28];
      8'h81: return x[29] & split;
      8'h84, 8'h85, 8'h86: return x[30 + c[1:0]];
      8'hA0, 8'hA1, 8'hA2, 8'hA3: return x[33 + c[1:0]];
      default: return 1'b0;
    endcase
  endfunction : f
  task automatic cmp(logic [5:0] got, logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t outputs %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    r = $random(seed);
    rnd <= r;
    sw <= r[5:0] & r[11:6] & r[17:12];
  end
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    cmp(a_o, 6'h00);
    cmp(s_o, 6'h00);
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      split <= (k >= 25);
      for (int c = 0; c < 6; c++) sel[8*c +: 8] <= tbl[(k + c) % 25];
      for (int i = 0; i < 12; i++) begin
        @(negedge clk);
        h = {h[2:0], {sw, v}};
        for (int c = 0; c < 6; c++) begin
          ea[c] = f(sel[8*c +: 8], h[0][36:0]) ^ h[1][37 + c];
          es[c] = f(sel[8*c +: 8], h[(sel[8*c +: 8] < 8'h24 ||
            sel[8*c+3 +: 5] == 5'h08) ? 3 : 1][36:0])
            ^ h[1][37 + c];
        end
        if (i > 4) begin
          cmp(a_o, ea);
          cmp(s_o, es);
        end
      end
    end
    give_verdict;
  end
endmodule : ecg_event_router_tb_top

// ===== verif/ecg_src_model.sv
`timescale 1ns/10ps
module ecg_src_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] rnd,
  output logic [36:0] v
);
  logic [11:0] pulse_r = '0;
  logic [1:0] cnt_r = '0;
  logic [22:0] lvl_r = '0;
  // Unclocked sources move off the edge and hold at least one cycle.
  always @(posedge clk) lvl_r <= #10 rnd[22:0];
  always @(posedge clk or negedge reset_n)
    if (!reset_n) {pulse_r, cnt_r} <= '0;
    else {pulse_r, cnt_r} <= {rnd[31:20] & ~pulse_r, cnt_r + 2'h1};
  assign v = {pulse_r[11:3], cnt_r[1], cnt_r[1], pulse_r[2:0], lvl_r};
endmodule : ecg_src_model
